// File: inc/bvs_pkg.sv
package bvs_pkg;

  // ****************************************
  // Flash geometry
  // ****************************************
  localparam int unsigned BVS_ADDR_W = 16;
  localparam int unsigned BVS_PAGE_BYTES = 512;
  // Lock byte sits at the very top of the last page
  localparam logic [15:0] BVS_LOCK_ADDR = 16'hFFFF;
  // Signature byte sits directly below the lock byte
  localparam logic [15:0] BVS_SIG_ADDR = BVS_LOCK_ADDR - 16'h0001;

  // ****************************************
  // Signature and vectors
  // ****************************************
  localparam logic [7:0] BVS_SIG_MARK = 8'hA5;
  localparam logic [15:0] BVS_RESET_VEC = 16'h0000;
  // Loader entry defaults to the start of the last page
  localparam logic [15:0] BVS_LOADER_VEC = 16'hFE00;

  // ****************************************
  // Flash read request and answer
  // ****************************************
  typedef struct packed {
    logic rd;
    logic [15:0] addr;
  } bvs_flash_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } bvs_flash_rsp_t;

  // ****************************************
  // Sequencer states
  // ****************************************
  typedef enum logic [3:0] {
    BVS_ST_HOLD = 4'h1,
    BVS_ST_READ = 4'h2,
    BVS_ST_WAIT = 4'h4,
    BVS_ST_RUN = 4'h8
  } bvs_state_t;

endpackage

// File: rtl/bvs_boot_select.sv
`timescale 1ns/1ps
module bvs_boot_select
  import bvs_pkg::*;
#(
  parameter logic [15:0] P_LOADER_VEC = BVS_LOADER_VEC
)
(
  // Clock and any reset source, ORed upstream
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Flash read port
  output bvs_flash_req_t o_flash_req,
  input wire bvs_flash_rsp_t i_flash_rsp,
  // Core start control
  output logic o_core_run,
  output logic [15:0] o_start_vec,
  output logic o_loader_present
);

  // ****************************************
  // Sequencer
  // ****************************************
  bvs_state_t state_q, state_d;
  bvs_flash_req_t req_q, req_d;
  logic run_q, run_d;
  logic [15:0] vec_q, vec_d;
  logic pres_q, pres_d;

  // Next state; core stays held until the signature answer is in
  always_comb
  begin
    state_d = state_q;
    req_d = '0;
    run_d = run_q;
    vec_d = vec_q;
    pres_d = pres_q;
    unique case (state_q)
      BVS_ST_HOLD:
      begin
        // One idle cycle after release lets flash settle
        state_d = BVS_ST_READ;
      end
      BVS_ST_READ:
      begin
        req_d.rd = 1'b1;
        req_d.addr = BVS_SIG_ADDR;
        state_d = BVS_ST_WAIT;
      end
      BVS_ST_WAIT:
      begin
        if (i_flash_rsp.valid)
        begin
          // Exact match only; erased 0xFF falls to reset vector
          pres_d = (i_flash_rsp.data == BVS_SIG_MARK);
          vec_d = pres_d ? P_LOADER_VEC : BVS_RESET_VEC;
          run_d = 1'b1;
          state_d = BVS_ST_RUN;
        end
      end
      BVS_ST_RUN:
      begin
        state_d = BVS_ST_RUN;
      end
      default:
      begin
        state_d = BVS_ST_HOLD;
      end
    endcase
  end

  // Every reset restarts the read, so a changed byte takes effect
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      state_q <= BVS_ST_HOLD;
      req_q <= '0;
      run_q <= 1'b0;
      vec_q <= BVS_RESET_VEC;
      pres_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      req_q <= req_d;
      run_q <= run_d;
      vec_q <= vec_d;
      pres_q <= pres_d;
    end
  end

  // ****************************************
  // Output registers
  // ****************************************
  // Outputs straight from flops
  assign o_flash_req = req_q;
  assign o_core_run = run_q;
  assign o_start_vec = vec_q;
  assign o_loader_present = pres_q;

  // ****************************************
  // Check bookkeeping
  // ****************************************
  // Only the checks read these; synthesis may prune them
  logic [1:0] reads_q, reads_d;
  logic [3:0] waits_q, waits_d;

  // Strobes and wait cycles since reset; both saturate so a runaway stays visible
  always_comb
  begin
    reads_d = reads_q;
    waits_d = waits_q;
    if (req_q.rd && reads_q != 2'h3)
    begin
      reads_d = reads_q + 2'h1;
    end
    if (state_q == BVS_ST_WAIT && waits_q != 4'hF)
    begin
      waits_d = waits_q + 4'h1;
    end
  end

  // Cleared by every reset, in step with the sequencer
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      reads_q <= 2'h0;
      waits_q <= 4'h0;
    end
    else
    begin
      reads_q <= reads_d;
      waits_q <= waits_d;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  // One clock domain; every check is muted while reset is high
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  // ****************************************
  // Address and strobe checks
  // ****************************************
  a_sig_addr_read: assert property (o_flash_req.rd |-> o_flash_req.addr == BVS_SIG_ADDR)
    else $error("signature read at wrong address");
  a_idle_addr_zero: assert property (!o_flash_req.rd |-> o_flash_req.addr == 16'h0000)
    else $error("read address left on the bus while idle");
  a_ready_to_read: assert property (state_q == BVS_ST_READ |=> o_flash_req.rd)
    else $error("read state did not strobe the flash");

  // ****************************************
  // Start decision checks
  // ****************************************
  a_mark_present: assert property (
    state_q == BVS_ST_WAIT && i_flash_rsp.valid && i_flash_rsp.data == 8'hA5
    |=> o_loader_present && o_start_vec == P_LOADER_VEC)
    else $error("marker not taken as present");
  a_other_absent: assert property (
    state_q == BVS_ST_WAIT && i_flash_rsp.valid && i_flash_rsp.data != 8'hA5 |=> !o_loader_present)
    else $error("non-marker taken as present");
  a_erased_absent: assert property (
    state_q == BVS_ST_WAIT && i_flash_rsp.valid && i_flash_rsp.data == 8'hFF |=> o_start_vec == 16'h0000)
    else $error("erased byte did not select address zero");
  a_loader_vector: assert property (
    $rose(o_core_run) && o_loader_present |-> o_start_vec == P_LOADER_VEC)
    else $error("loader present but wrong vector");
  a_zero_vector: assert property (o_core_run && !o_loader_present |-> o_start_vec == 16'h0000)
    else $error("loader absent but vector not zero");
  a_loader_page: assert property (
    o_core_run && o_loader_present |-> o_start_vec >= (BVS_LOCK_ADDR - 16'(BVS_PAGE_BYTES - 1)))
    else $error("loader entry outside the last page");
  a_present_needs_run: assert property (o_loader_present |-> o_core_run)
    else $error("loader flagged before core release");
  a_quiet_before_run: assert property (!o_core_run |-> o_start_vec == 16'h0000 && !o_loader_present)
    else $error("start decision shown before release");

  // ****************************************
  // Sequencing checks
  // ****************************************
  a_hold_quiet: assert property (state_q == BVS_ST_HOLD |-> !o_flash_req.rd && !o_core_run)
    else $error("activity during the settle cycle");
  a_read_after_hold: assert property (state_q == BVS_ST_HOLD |-> ##2 o_flash_req.rd)
    else $error("signature read not issued two cycles after reset");
  a_wait_no_run: assert property (state_q == BVS_ST_WAIT |-> !o_core_run)
    else $error("core released while waiting for flash");
  a_read_before_run: assert property ($rose(o_core_run) |-> $past(state_q) == BVS_ST_WAIT)
    else $error("core released without signature read");
  a_req_one_cycle: assert property (o_flash_req.rd |=> !o_flash_req.rd)
    else $error("read strobe longer than one cycle");
  a_single_read: assert property (reads_q <= 2'h1)
    else $error("more than one signature read per reset");
  a_run_needs_read: assert property (o_core_run |-> reads_q == 2'h1)
    else $error("core released without a completed read");
  a_wait_counted: assert property ($rose(o_core_run) |-> waits_q != 4'h0)
    else $error("core released before the answer could arrive");
  a_no_read_in_run: assert property (state_q == BVS_ST_RUN |-> !o_flash_req.rd)
    else $error("flash read after the core was released");
  a_state_onehot: assert property ($onehot(state_q))
    else $error("sequencer state not one-hot");
  a_run_sticky: assert property (o_core_run |=> o_core_run && $stable(o_start_vec))
    else $error("start decision changed while running");

  // ****************************************
  // Coverage
  // ****************************************
  // Main boot cases, a slow answer and a near miss
  c_loader_boot: cover property ($rose(o_core_run) && o_loader_present);
  c_plain_boot: cover property ($rose(o_core_run) && !o_loader_present);
  c_erased_flash: cover property (state_q == BVS_ST_WAIT && i_flash_rsp.valid && i_flash_rsp.data == 8'hFF);
  c_slow_flash: cover property ($rose(o_core_run) && waits_q > 4'h4);
  c_near_miss: cover property (state_q == BVS_ST_WAIT && i_flash_rsp.valid && i_flash_rsp.data == 8'hA4);

endmodule

// File: sim/bvs_flash_model.sv
`timescale 1ns/1ps
module bvs_flash_model
  import bvs_pkg::*;
(
  // Clock and read port
  input wire logic i_clk,
  input wire bvs_flash_req_t i_req,
  // Stored byte and answer lag
  input wire logic [7:0] i_sig,
  input wire logic [3:0] i_lag,
  output bvs_flash_rsp_t o_rsp
);
  logic [3:0] cnt_q = 4'h0;
  logic [7:0] dat_q = 8'h00;
  // Idle data is inverted so a stale byte never passes
  assign o_rsp = '{valid: cnt_q == 4'h1, data: (cnt_q == 4'h1) ? dat_q : ~dat_q};
  // Only the byte under the lock byte holds the mark
  always @(posedge i_clk)
  begin
    if (i_req.rd)
    begin
      cnt_q <= i_lag;
      dat_q <= (i_req.addr == BVS_SIG_ADDR) ? i_sig : 8'hFF;
    end
    else if (cnt_q != 4'h0)
      cnt_q <= cnt_q - 4'h1;
  end
endmodule

// File: sim/test_boot_vector_select.sv
`timescale 1ns/1ps
module test_boot_vector_select
  import bvs_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] sig = 8'hA5;
  logic [3:0] lag = 4'h1;
  logic run, pres;
  logic [15:0] vec;
  logic [15:0] rd_addr = 16'h0000;
  bvs_flash_req_t req;
  bvs_flash_rsp_t rsp;
  int fails = 0;
  int compares = 0;
  int reads = 0;
  always #20 clk = ~clk;
  bvs_boot_select DUT (.i_clk(clk), .i_sys_rst(rst), .o_flash_req(req), .i_flash_rsp(rsp),
    .o_core_run(run), .o_start_vec(vec), .o_loader_present(pres));
  bvs_flash_model FLASH (.i_clk(clk), .i_req(req), .i_sig(sig), .i_lag(lag), .o_rsp(rsp));
  // Strobe address and strobe count since the last reset
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      reads <= 0;
    else if (req.rd === 1'b1)
    begin
      reads <= reads + 1;
      rd_addr <= req.addr;
    end
  end
  task automatic cmp(input logic [15:0] e, input logic [15:0] g, input string n);
    compares++;
    if (g !== e)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_of_test();
    if (fails == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Full reset cycle; release must follow the answer by one edge
  task automatic boot(input logic [7:0] s, input logic [3:0] l);
    int n;
    sig = s;
    lag = l;
    rst = 1'b1;
    repeat (3) @(negedge clk);
    cmp(16'h0000, {15'h0000, run}, "run in reset");
    cmp(BVS_RESET_VEC, vec, "vec in reset");
    rst = 1'b0;
    n = 0;
    while (run !== 1'b1 && n < 30)
    begin
      @(negedge clk);
      n++;
    end
    cmp(16'(3 + l), 16'(n), "release cycle");
    cmp(16'h0001, 16'(reads), "reads per reset");
    cmp(BVS_SIG_ADDR, rd_addr, "read addr");
  endtask
  task automatic t_present();
    boot(8'hA5, 4'h1);
    cmp(BVS_LOADER_VEC, vec, "loader vec");
    cmp(16'h0001, {15'h0000, pres}, "present");
  endtask
  // Erased, near misses and swapped nibbles all mean absent
  task automatic t_absent();
    logic [7:0] v [5] = '{8'hFF, 8'hA4, 8'hA7, 8'h5A, 8'h00};
    foreach (v[i])
    begin
      boot(v[i], 4'h2);
      cmp(BVS_RESET_VEC, vec, "reset vec");
      cmp(16'h0000, {15'h0000, pres}, "absent");
    end
  endtask
  // Byte changed between resets, slow flash, outputs then hold
  task automatic t_refresh();
    boot(8'hA5, 4'h1);
    boot(8'hFF, 4'h9);
    repeat (6) @(negedge clk);
    cmp(BVS_RESET_VEC, vec, "reread vec");
    cmp(16'h0001, {15'h0000, run}, "run holds");
  endtask
  initial
  begin
    t_present();
    t_absent();
    t_refresh();
    end_of_test();
  end
  // Watchdog well beyond the eight boots
  initial
  begin
    #20us;
    fails++;
    end_of_test();
  end
endmodule
